// *** shared/dhc_consts.vh ***
`ifndef DHC_CONSTS_VH
`define DHC_CONSTS_VH
`define DHC_EXT_W      2
`define DHC_NUM_CMP    2
`define DHC_ADDR_W     32
`define DHC_DATA_W     32
`define DHC_CTRL_W     4
`define DHC_ST_RUN     4'h1
`define DHC_ST_FETCH   4'h2
`define DHC_ST_DRAIN   4'h4
`define DHC_ST_HALT    4'h8
`endif

// *** rtl/dhc_watch_cmp.v ***
`timescale 1ns/1ps
`default_nettype none
`include "dhc_consts.vh"
// One watchpoint comparator: masked compare of address, data, control and
// the external condition. The enable bit is deliberately not an input.
module dhc_watch_cmp #(
  parameter AW = `DHC_ADDR_W,
  parameter DW = `DHC_DATA_W,
  parameter CW = `DHC_CTRL_W,
  parameter EW = `DHC_EXT_W
) (
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] data,
  input  wire [CW-1:0] ctrl,
  input  wire [EW-1:0] ext,
  input  wire [AW-1:0] addrVal,
  input  wire [AW-1:0] addrMask,
  input  wire [DW-1:0] dataVal,
  input  wire [DW-1:0] dataMask,
  input  wire [CW-1:0] ctrlVal,
  input  wire [CW-1:0] ctrlMask,
  input  wire [EW-1:0] extVal,
  input  wire [EW-1:0] extMask,
  output wire          match
);
  // Mask bit high means the bit is ignored.
  assign match = (((addr ^ addrVal) & ~addrMask) == {AW{1'b0}}) &&
                 (((data ^ dataVal) & ~dataMask) == {DW{1'b0}}) &&
                 (((ctrl ^ ctrlVal) & ~ctrlMask) == {CW{1'b0}}) &&
                 (((ext ^ extVal) & ~extMask) == {EW{1'b0}});
endmodule // dhc_watch_cmp
`default_nettype wire

// *** rtl/dhc_debug_halt.v ***
`timescale 1ns/1ps
`default_nettype none
`include "dhc_consts.vh"
module dhc_debug_halt #(
  parameter AW = `DHC_ADDR_W,
  parameter DW = `DHC_DATA_W,
  parameter CW = `DHC_CTRL_W,
  parameter EW = `DHC_EXT_W,
  parameter NC = `DHC_NUM_CMP
) (
  input  wire             clk,
  input  wire             reset,
  input  wire             ext_halt_tag_in,
  input  wire             halt_request_in,
  input  wire             halt_logic_enable_in,
  input  wire [EW-1:0]    external_condition_in,
  input  wire             accessValid,
  input  wire             accessIsFetch,
  input  wire             fetchExecuted,
  input  wire             fetchFlushed,
  input  wire             instrDone,
  input  wire             restartReq,
  input  wire [AW-1:0]    busAddr,
  input  wire [DW-1:0]    busData,
  input  wire [CW-1:0]    busCtrl,
  input  wire [NC*AW-1:0] cmpAddrVal,
  input  wire [NC*AW-1:0] cmpAddrMask,
  input  wire [NC*DW-1:0] cmpDataVal,
  input  wire [NC*DW-1:0] cmpDataMask,
  input  wire [NC*CW-1:0] cmpCtrlVal,
  input  wire [NC*CW-1:0] cmpCtrlMask,
  input  wire [NC*EW-1:0] cmpExtVal,
  input  wire [NC*EW-1:0] cmpExtMask,
  input  wire [NC-1:0]    cmpBreakEn,
  input  wire [NC-1:0]    cmpWatchEn,
  input  wire             rxWrite,
  input  wire             rxRead,
  input  wire             txWrite,
  input  wire             txRead,
  output reg              halted_ack_out,
  output reg              comms_rx_full_out,
  output reg              comms_tx_empty_out,
  output reg  [NC-1:0]    watch_match_out,
  output reg              coreHalted
);
  localparam [3:0] ST_RUN   = `DHC_ST_RUN;
  localparam [3:0] ST_FETCH = `DHC_ST_FETCH;
  localparam [3:0] ST_DRAIN = `DHC_ST_DRAIN;
  localparam [3:0] ST_HALT  = `DHC_ST_HALT;

  reg  [3:0]    state_q;
  reg  [3:0]    state_d;
  reg           rxFull_q;
  reg           txEmpty_q;
  wire [NC-1:0] cmpMatch;
  wire          bkptHit;
  wire          watchHit;
  wire          tagFetch;
  wire          tagData;
  wire          reqHalt;

  genvar g;
  generate
    for (g = 0; g < NC; g = g + 1)
    begin : gCmp
      dhc_watch_cmp #(
        .AW(AW),
        .DW(DW),
        .CW(CW),
        .EW(EW)
      ) uCmp (
        .addr     (busAddr),
        .data     (busData),
        .ctrl     (busCtrl),
        .ext      (external_condition_in),
        .addrVal  (cmpAddrVal[g*AW +: AW]),
        .addrMask (cmpAddrMask[g*AW +: AW]),
        .dataVal  (cmpDataVal[g*DW +: DW]),
        .dataMask (cmpDataMask[g*DW +: DW]),
        .ctrlVal  (cmpCtrlVal[g*CW +: CW]),
        .ctrlMask (cmpCtrlMask[g*CW +: CW]),
        .extVal   (cmpExtVal[g*EW +: EW]),
        .extMask  (cmpExtMask[g*EW +: EW]),
        .match    (cmpMatch[g])
      );
    end
  endgenerate

  // Halt sources are synchronous to clk by the far party's contract.
  assign bkptHit  = halt_logic_enable_in & accessValid &
                    (ext_halt_tag_in | |(cmpMatch & cmpBreakEn));
  assign watchHit = halt_logic_enable_in & accessValid &
                    ~accessIsFetch & |(cmpMatch & cmpWatchEn);
  assign tagFetch = bkptHit & accessIsFetch;
  assign tagData  = (bkptHit & ~accessIsFetch) | watchHit;
  assign reqHalt  = halt_logic_enable_in & halt_request_in;

  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_RUN:
      begin
        if ((tagData | reqHalt) & instrDone)
          state_d = ST_HALT;
        else if (tagData | reqHalt)
          state_d = ST_DRAIN;
        else if (tagFetch)
          state_d = ST_FETCH;
      end
      ST_FETCH:
      begin
        if (fetchExecuted)
          state_d = ST_HALT;
        else if (tagData | reqHalt)
          state_d = ST_DRAIN;
        else if (fetchFlushed)
          state_d = ST_RUN;
      end
      ST_DRAIN:
      begin
        if (instrDone)
          state_d = ST_HALT;
      end
      ST_HALT:
      begin
        if (restartReq)
          state_d = ST_RUN;
      end
      default:
        state_d = ST_RUN;
    endcase
    // A dropped enable abandons any pending or active halt.
    if (!halt_logic_enable_in)
      state_d = ST_RUN;
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q            <= ST_RUN;
      rxFull_q           <= 1'b0;
      txEmpty_q          <= 1'b1;
      halted_ack_out     <= 1'b0;
      coreHalted         <= 1'b0;
      comms_rx_full_out  <= 1'b0;
      comms_tx_empty_out <= 1'b1;
      watch_match_out    <= {NC{1'b0}};
    end
    else
    begin
      state_q <= state_d;
      // Write wins over a read in the same cycle so no word is lost.
      if (rxWrite)
        rxFull_q <= 1'b1;
      else if (rxRead)
        rxFull_q <= 1'b0;
      if (txWrite)
        txEmpty_q <= 1'b0;
      else if (txRead)
        txEmpty_q <= 1'b1;
      halted_ack_out     <= (state_d == ST_HALT) & halt_logic_enable_in;
      coreHalted         <= (state_d == ST_HALT);
      comms_rx_full_out  <= rxWrite | (rxFull_q & ~rxRead);
      comms_tx_empty_out <= ~txWrite & (txEmpty_q | txRead);
      watch_match_out    <= cmpMatch;
    end
  end
endmodule // dhc_debug_halt
`default_nettype wire

// *** testbench/dhc_dbg_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module dhc_dbg_host (
  input  wire       clk,
  input  wire [4:0] cmd,
  output reg        ext_halt_tag_in,
  output reg        halt_request_in,
  output reg        halt_logic_enable_in,
  output reg  [1:0] external_condition_in
);
  // Pins are registered on clk; the halt tag and halt request start low, as an idle debugger leaves them.
  initial {ext_halt_tag_in, halt_request_in} = 2'h0;
  always @(posedge clk)
    {ext_halt_tag_in, halt_request_in, halt_logic_enable_in,
      external_condition_in} <= cmd;
endmodule // dhc_dbg_host
`default_nettype wire

// *** testbench/dhc_debug_halt_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module dhc_debug_halt_chk (
  input wire clk,
  input wire reset,
  input wire halt_request_in,
  input wire halt_logic_enable_in,
  input wire instrDone,
  input wire fetchExecuted,
  input wire restartReq,
  input wire rxWrite,
  input wire rxRead,
  input wire txWrite,
  input wire halted_ack_out,
  input wire comms_rx_full_out,
  input wire comms_tx_empty_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_en; !halt_logic_enable_in |=> !halted_ack_out; endproperty
  a_en: assert property (p_en) else $error("ack not low");
  property p_rq;
    halt_logic_enable_in && halt_request_in && instrDone |=> halted_ack_out;
  endproperty
  a_rq: assert property (p_rq) else $error("no halt");
  property p_up;
    $rose(halted_ack_out) |-> $past(instrDone) || $past(fetchExecuted);
  endproperty
  a_up: assert property (p_up) else $error("early halt");
  property p_hd;
    halted_ack_out && !restartReq && halt_logic_enable_in |=> halted_ack_out;
  endproperty
  a_hd: assert property (p_hd) else $error("ack lost");
  property p_rs; halted_ack_out && restartReq |=> !halted_ack_out; endproperty
  a_rs: assert property (p_rs) else $error("ack stuck");
  property p_rx; rxWrite |=> comms_rx_full_out; endproperty
  a_rx: assert property (p_rx) else $error("rx not full");
  property p_rd; rxRead && !rxWrite |=> !comms_rx_full_out; endproperty
  a_rd: assert property (p_rd) else $error("rx not empty");
  property p_tx; txWrite |=> !comms_tx_empty_out; endproperty
  a_tx: assert property (p_tx) else $error("tx still empty");
  c_hlt: cover property ($rose(halted_ack_out));
  c_rx: cover property ($rose(comms_rx_full_out));
  c_tx: cover property ($fell(comms_tx_empty_out));
endmodule // dhc_debug_halt_chk
bind dhc_debug_halt dhc_debug_halt_chk chk_u (.*);
`default_nettype wire

// *** testbench/tb_dhc_debug_halt.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_dhc_debug_halt;
  logic        clk, reset, accessValid, accessIsFetch, fetchExecuted;
  logic        fetchFlushed, instrDone, restartReq, rxWrite, rxRead;
  logic        txWrite, txRead, ext_halt_tag_in, halt_request_in;
  logic        halt_logic_enable_in, halted_ack_out, coreHalted;
  logic        comms_rx_full_out, comms_tx_empty_out;
  logic [1:0]  external_condition_in, watch_match_out;
  logic [1:0]  cmpBreakEn, cmpWatchEn;
  logic [3:0]  busCtrl, cmpExtVal, cmpExtMask;
  logic [4:0]  cmd;
  logic [7:0]  cmpCtrlVal, cmpCtrlMask;
  logic [31:0] busAddr, busData;
  logic [63:0] cmpAddrVal, cmpAddrMask, cmpDataVal, cmpDataMask;
  int          n_errors, checks;
  dhc_debug_halt dut_u (.*);
  dhc_dbg_host host_u (.*);
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input string nm, input logic [7:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task t_req;
    cmd = 5'h0c;
    cyc(2);
    chk("ack wait", halted_ack_out, 8'h00);
    instrDone = 1'h1;
    cyc(1);
    {instrDone, cmd} = 6'h04;
    chk("ack req", halted_ack_out, 8'h01);
    chk("core halted", coreHalted, 8'h01);
    cyc(3);
    chk("ack hold", halted_ack_out, 8'h01);
    restartReq = 1'h1;
    cyc(1);
    restartReq = 1'h0;
    chk("ack restart", halted_ack_out, 8'h00);
    chk("core run", coreHalted, 8'h00);
    $display("t_req done");
  endtask
  task t_tag(input logic isF, input logic ok);
    cmd = 5'h14;
    accessIsFetch = isF;
    cyc(1);
    accessValid = 1'h1;
    cyc(1);
    {accessValid, cmd} = 6'h04;
    cyc(2);
    chk("ack pend", halted_ack_out, 8'h00);
    {fetchExecuted, fetchFlushed, instrDone} = {isF & ok, isF & !ok, !isF};
    cyc(1);
    {fetchExecuted, fetchFlushed, instrDone, restartReq} = {3'h0, ok};
    chk("ack tag", halted_ack_out, {7'h0, ok});
    cyc(1);
    restartReq = 1'h0;
    $display("t_tag done");
  endtask
  task t_en;
    {cmd, instrDone} = 6'h11;
    cyc(3);
    chk("ack blocked", halted_ack_out, 8'h00);
    cmd = 5'h0c;
    cyc(2);
    {instrDone, cmd} = 6'h00;
    chk("ack en", halted_ack_out, 8'h01);
    cyc(2);
    chk("ack drop", halted_ack_out, 8'h00);
    $display("t_en done");
  endtask
  task t_comms;
    for (int i = 0; i < 4; i++)
    begin
      {rxWrite, rxRead, txWrite, txRead} = 4'h8 >> i;
      cyc(1);
      {rxWrite, rxRead, txWrite, txRead} = 4'h0;
      chk("comms", {comms_rx_full_out, comms_tx_empty_out},
        (8'hd1 >> (6 - 2 * i)) & 8'h03);
    end
    $display("t_comms done");
  endtask
  task t_watch;
    for (int e = 0; e < 4; e++)
    begin
      cmd = 5'h04 | e[1:0];
      cyc(2);
      chk("match", watch_match_out, {e == 2, e == 1});
    end
    $display("t_watch done");
  endtask
  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    {accessValid, accessIsFetch, fetchExecuted, fetchFlushed} = 4'h0;
    {instrDone, restartReq, rxWrite, rxRead, txWrite, txRead} = 6'h00;
    {busAddr, busData, busCtrl, cmpAddrVal, cmpDataVal, cmpCtrlVal} = 204'h0;
    {cmpAddrMask, cmpDataMask, cmpCtrlMask} = ~136'h0;
    {cmpBreakEn, cmpWatchEn, cmpExtMask, cmpExtVal} = 12'h009;
    {reset, cmd} = 6'h24;
    cyc(2);
    chk("reset", {halted_ack_out, comms_rx_full_out, comms_tx_empty_out,
      watch_match_out}, 8'h04);
    reset = 1'h0;
    cyc(1);
    t_req;
    t_tag(1'h1, 1'h1);
    t_tag(1'h1, 1'h0);
    t_tag(1'h0, 1'h1);
    t_en;
    t_comms;
    t_watch;
    print_verdict;
  end
endmodule // tb_dhc_debug_halt
`default_nettype wire
